// ===== hdl/crs_map.svh
// Register offsets, field positions and reset values of the CRC scanner
`ifndef CRS_MAP_SVH
`define CRS_MAP_SVH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CRS_OFF_DATA_LOW    12'h000
`define CRS_OFF_DATA_HIGH   12'h004
`define CRS_OFF_ACC_HIGH    12'h008
`define CRS_OFF_ACC_LOW     12'h00c
`define CRS_OFF_SHIFT_HIGH  12'h010
`define CRS_OFF_SHIFT_LOW   12'h014
`define CRS_OFF_TAPS_HIGH   12'h018
`define CRS_OFF_TAPS_LOW    12'h01c
`define CRS_OFF_SCAN_CTRL   12'h020
`define CRS_OFF_CUR_HIGH    12'h024
`define CRS_OFF_CUR_LOW     12'h028
`define CRS_OFF_END_HIGH    12'h02c
`define CRS_OFF_END_LOW     12'h030
`define CRS_OFF_CRC_CTRL    12'h034
`define CRS_OFF_CRC_LEN     12'h038
// ****************************************************************
// Scanner control fields
// ****************************************************************
`define CRS_SC_EN           7
`define CRS_SC_GO           6
`define CRS_SC_BUSY         5
`define CRS_SC_INVALID      4
`define CRS_SC_INTERRUPT_MANAGEMENT         3
// ****************************************************************
// CRC control fields
// ****************************************************************
`define CRS_CC_EN           7
`define CRS_CC_GO           6
`define CRS_CC_BUSY         5
`define CRS_CC_ZERO_AUGMENT_MODE         4
`define CRS_CC_SHIFT_DIRECTION       1
`define CRS_CC_FULL         0
// ****************************************************************
// Reset values and sizes
// ****************************************************************
`define CRS_RST_BYTE        8'h00
`define CRS_RST_WORD        16'h0000
`define CRS_MEM_WORDS       17'h04000
`endif

// ===== hdl/crs_pkg.sv
// Types shared by the CRC scanner
package crs_pkg;
  // ****************************************************************
  // Scanner access modes and fetch states
  // ****************************************************************
  typedef enum logic [1:0] {
    CRS_MODE_CONCURRENT = 2'h0,
    CRS_MODE_BURST      = 2'h1,
    CRS_MODE_PEEK       = 2'h2,
    CRS_MODE_TRIGGERED  = 2'h3
  } crs_mode_t;

  typedef enum logic [1:0] {
    CRS_ST_IDLE  = 2'b01,
    CRS_ST_FETCH = 2'b10
  } crs_scan_st_t;

  // ****************************************************************
  // Whole state of the block
  // ****************************************************************
  typedef struct packed {
    crs_scan_st_t scan_st;
    logic         scan_en;
    logic         scan_go_a;
    logic         interrupt_management;
    crs_mode_t    mode;
    logic         trig_pend;
    logic [15:0]  scan_current_address;
    logic [15:0]  scan_end_address;
    logic [15:0]  crc_input_word;
    logic         full;
    logic [15:0]  shifter;
    logic [4:0]   bit_cnt;
    logic [15:0]  crc_accumulator;
    logic [15:1]  taps;
    logic [3:0]   data_length_field;
    logic [3:0]   polynomial_length_field;
    logic         shift_direction;
    logic         zero_augment_mode;
    logic         crc_en;
    logic         crc_shift_start;
    logic [31:0]  prdata;
    logic         pslverr;
  } crs_state_t;
endpackage : crs_pkg

// ===== hdl/crs_top.sv
// CRC engine with program memory scanner and APB register slave
// Operation
// - Writing data low byte loads pending word toward the shifter
// - Accumulator bytes read and write the accumulator; reset zero
// - Shifter bytes are read-only, show shifter, reset zero
// - Tap bits 15..1 enable feedback XOR; bit 0 reads one
// - Scanner enable runs scanner; clearing resets its state machine
// - Clearing scanner enable leaves all other registers unchanged; the pending trigger clears
// - With go set, each CRC ready fetches one word per mode
// - Hardware clears go when current passes end and no fetch
// - Concurrent/triggered with management: interrupts mask go
// - Burst stalls CPU; management masks go; peek ignores it
// - Busy reads one while fetching or while go is effective and CRC signals ready
// - Invalid flags a current address beyond program memory
// - Current address holds start and increments per fetch
// - Address writes ignored while go is set
// - End address bounds the scan range
// - Length fields hold data length and poly order minus one
// - Full reads one while a word waits for the shifter
// - Shift direction set sends LSB first, clear MSB first
// - Augment mode set feeds data behind zeros
`timescale 1ns/1ps
`include "crs_map.svh"

module crs_top #(
  parameter logic [16:0] MEM_WORDS = `CRS_MEM_WORDS
) (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             mem_req_o,
  output logic      [15:0] mem_addr_o,
  input  wire logic        mem_ack_i,
  input  wire logic [15:0] mem_data_i,
  input  wire logic        mem_idle_i,
  input  wire logic        trigger_i,
  input  wire logic        irq_active_i,
  output logic             cpu_stall_o,
  output logic             crc_busy_o
);
  // ****************************************************************
  // State and decode
  // ****************************************************************
  crs_pkg::crs_state_t q;
  crs_pkg::crs_state_t d;
  logic        wr;
  logic        setup;
  logic        go_eff;
  logic        crc_ready;
  logic        slot;
  logic        start;
  logic        done;
  logic        busy;
  logic        invalid;
  logic        past_end;
  logic        step;
  logic        dbit;
  logic        fb;
  logic [16:0] pmask;
  logic [15:0] acc_n;
  logic [7:0]  sc_rd;
  logic [7:0]  cc_rd;
  logic [31:0] rdata;
  logic        hit;

  assign wr    = psel_i & penable_i & pwrite_i;
  assign setup = psel_i & ~penable_i;

  // Interrupt masking of go; peek mode ignores management
  assign go_eff = q.scan_en & q.scan_go_a &
                  ~(q.interrupt_management & irq_active_i &
                    (q.mode != crs_pkg::CRS_MODE_PEEK));
  assign crc_ready = q.crc_en & ~q.full;
  always_comb begin
    unique case (q.mode)
      crs_pkg::CRS_MODE_BURST:     slot = 1'b1;
      crs_pkg::CRS_MODE_TRIGGERED: slot = q.trig_pend;
      crs_pkg::CRS_MODE_PEEK:      slot = mem_idle_i;
      crs_pkg::CRS_MODE_CONCURRENT: slot = mem_idle_i;
    endcase
  end
  assign past_end = q.scan_current_address > q.scan_end_address;
  assign start = (q.scan_st == crs_pkg::CRS_ST_IDLE) & go_eff &
                 crc_ready & slot & ~past_end;
  assign done  = (q.scan_st == crs_pkg::CRS_ST_FETCH) & mem_ack_i;
  assign busy  = (q.scan_st == crs_pkg::CRS_ST_FETCH) |
                 (go_eff & crc_ready);
  assign invalid = {1'b0, q.scan_current_address} >= MEM_WORDS;

  // ****************************************************************
  // CRC bit step
  // ****************************************************************
  assign step  = q.crc_en & q.crc_shift_start & (q.bit_cnt != 5'h00);
  assign dbit  = q.shift_direction ? q.shifter[0] :
                 q.shifter[q.data_length_field];
  assign pmask = (17'h00002 << q.polynomial_length_field) - 17'h00001;
  always_comb begin
    if (q.zero_augment_mode) begin
      fb    = q.crc_accumulator[q.polynomial_length_field];
      acc_n = {q.crc_accumulator[14:0], dbit};
    end else begin
      fb    = q.crc_accumulator[q.polynomial_length_field] ^ dbit;
      acc_n = {q.crc_accumulator[14:0], 1'b0};
    end
    if (fb) begin
      acc_n = acc_n ^ {q.taps, 1'b1};
    end
    acc_n = acc_n & pmask[15:0];
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************
  assign sc_rd = {q.scan_en, q.scan_go_a, busy, invalid,
                  q.interrupt_management, 1'b0, q.mode};
  assign cc_rd = {q.crc_en, q.crc_shift_start,
                  q.full | (q.bit_cnt != 5'h00), q.zero_augment_mode,
                  2'b00, q.shift_direction, q.full};
  always_comb begin
    rdata = 32'h0000_0000;
    hit   = 1'b1;
    unique case (paddr_i)
      `CRS_OFF_DATA_LOW:   rdata[7:0] = q.crc_input_word[7:0];
      `CRS_OFF_DATA_HIGH:  rdata[7:0] = q.crc_input_word[15:8];
      `CRS_OFF_ACC_HIGH:   rdata[7:0] = q.crc_accumulator[15:8];
      `CRS_OFF_ACC_LOW:    rdata[7:0] = q.crc_accumulator[7:0];
      `CRS_OFF_SHIFT_HIGH: rdata[7:0] = q.shifter[15:8];
      `CRS_OFF_SHIFT_LOW:  rdata[7:0] = q.shifter[7:0];
      `CRS_OFF_TAPS_HIGH:  rdata[7:0] = q.taps[15:8];
      `CRS_OFF_TAPS_LOW:   rdata[7:0] = {q.taps[7:1], 1'b1};
      `CRS_OFF_SCAN_CTRL:  rdata[7:0] = sc_rd;
      `CRS_OFF_CUR_HIGH:   rdata[7:0] = q.scan_current_address[15:8];
      `CRS_OFF_CUR_LOW:    rdata[7:0] = q.scan_current_address[7:0];
      `CRS_OFF_END_HIGH:   rdata[7:0] = q.scan_end_address[15:8];
      `CRS_OFF_END_LOW:    rdata[7:0] = q.scan_end_address[7:0];
      `CRS_OFF_CRC_CTRL:   rdata[7:0] = cc_rd;
      `CRS_OFF_CRC_LEN:    rdata[7:0] = {q.data_length_field,
                                         q.polynomial_length_field};
      default:             hit = 1'b0;
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    d = q;
    // APB read data and error are captured in the setup cycle
    if (setup) begin
      d.prdata  = rdata;
      d.pslverr = ~hit;
    end
    // Trigger events latch until a fetch start in any mode consumes them
    if (start) begin
      d.trig_pend = 1'b0;
    end
    if (trigger_i) begin
      d.trig_pend = 1'b1;
    end
    // Scanner fetch machine
    unique case (q.scan_st)
      crs_pkg::CRS_ST_IDLE: begin
        if (start) begin
          d.scan_st = crs_pkg::CRS_ST_FETCH;
        end else if (q.scan_go_a & past_end) begin
          d.scan_go_a = 1'b0;
        end
      end
      crs_pkg::CRS_ST_FETCH: begin
        if (mem_ack_i) begin
          d.scan_st = crs_pkg::CRS_ST_IDLE;
          d.crc_input_word = mem_data_i;
          d.full = 1'b1;
          d.scan_current_address = q.scan_current_address + 16'h0001;
        end
      end
    endcase
    // CRC shifter: load pending word, then one bit per cycle
    if (q.crc_en & q.crc_shift_start & (q.bit_cnt == 5'h00) & q.full) begin
      d.shifter = q.crc_input_word;
      d.bit_cnt = {1'b0, q.data_length_field} + 5'h01;
      d.full    = done;
    end else if (step) begin
      d.shifter = q.shift_direction ? {1'b0, q.shifter[15:1]} :
                                      {q.shifter[14:0], 1'b0};
      d.bit_cnt = q.bit_cnt - 5'h01;
      d.crc_accumulator = acc_n;
    end
    // Register writes take effect at the access phase
    if (wr) begin
      unique case (paddr_i)
        `CRS_OFF_DATA_LOW: begin
          d.crc_input_word[7:0] = pwdata_i[7:0];
          d.full = 1'b1;
        end
        `CRS_OFF_DATA_HIGH: d.crc_input_word[15:8] = pwdata_i[7:0];
        `CRS_OFF_ACC_HIGH:
          d.crc_accumulator[15:8] = pwdata_i[7:0];
        `CRS_OFF_ACC_LOW:
          d.crc_accumulator[7:0] = pwdata_i[7:0];
        `CRS_OFF_TAPS_HIGH: d.taps[15:8] = pwdata_i[7:0];
        `CRS_OFF_TAPS_LOW:  d.taps[7:1] = pwdata_i[7:1];
        `CRS_OFF_SCAN_CTRL: begin
          d.scan_en = pwdata_i[`CRS_SC_EN];
          // A hardware end-of-range clear loses to a software set
          d.scan_go_a = pwdata_i[`CRS_SC_GO];
          d.interrupt_management = pwdata_i[`CRS_SC_INTERRUPT_MANAGEMENT];
          d.mode = crs_pkg::crs_mode_t'(pwdata_i[1:0]);
        end
        `CRS_OFF_CUR_HIGH: if (!q.scan_go_a) begin
          d.scan_current_address[15:8] = pwdata_i[7:0];
        end
        `CRS_OFF_CUR_LOW: if (!q.scan_go_a) begin
          d.scan_current_address[7:0] = pwdata_i[7:0];
        end
        `CRS_OFF_END_HIGH: if (!q.scan_go_a) begin
          d.scan_end_address[15:8] = pwdata_i[7:0];
        end
        `CRS_OFF_END_LOW: if (!q.scan_go_a) begin
          d.scan_end_address[7:0] = pwdata_i[7:0];
        end
        `CRS_OFF_CRC_CTRL: begin
          d.crc_en = pwdata_i[`CRS_CC_EN];
          d.crc_shift_start = pwdata_i[`CRS_CC_GO];
          d.zero_augment_mode = pwdata_i[`CRS_CC_ZERO_AUGMENT_MODE];
          d.shift_direction = pwdata_i[`CRS_CC_SHIFT_DIRECTION];
        end
        `CRS_OFF_CRC_LEN: begin
          d.data_length_field = pwdata_i[7:4];
          d.polynomial_length_field = pwdata_i[3:0];
        end
        default: ;
      endcase
    end
    // Disabled scanner: its machine state returns to idle and the pending trigger clears
    if (!d.scan_en) begin
      d.scan_st   = crs_pkg::CRS_ST_IDLE;
      d.trig_pend = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= '0;
      q.scan_st <= crs_pkg::CRS_ST_IDLE;
      q.mode <= crs_pkg::CRS_MODE_CONCURRENT;
      q.crc_accumulator <= `CRS_RST_WORD;
      q.shifter <= `CRS_RST_WORD;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata_o    = q.prdata;
  assign pready_o    = psel_i & penable_i;
  assign pslverr_o   = psel_i & penable_i & q.pslverr;
  assign mem_req_o   = q.scan_st == crs_pkg::CRS_ST_FETCH;
  assign mem_addr_o  = q.scan_current_address;
  assign cpu_stall_o = go_eff & ~past_end &
                       (q.mode == crs_pkg::CRS_MODE_BURST);
  assign crc_busy_o  = q.full | (q.bit_cnt != 5'h00);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_data_fill;
    wr & (paddr_i == `CRS_OFF_DATA_LOW) |=> q.full;
  endproperty
  a_data_fill: assert property (p_data_fill)
    else $error("data low write did not mark word full");

  property p_acc_write;
    wr & (paddr_i == `CRS_OFF_ACC_LOW) |=>
      q.crc_accumulator[7:0] == $past(pwdata_i[7:0]);
  endproperty
  a_acc_write: assert property (p_acc_write)
    else $error("accumulator low byte write lost");

  property p_taps_bit0;
    setup & (paddr_i == `CRS_OFF_TAPS_LOW) |=> prdata_o[0];
  endproperty
  a_taps_bit0: assert property (p_taps_bit0)
    else $error("tap low bit 0 did not read one");

  property p_en_idle;
    !q.scan_en |-> q.scan_st == crs_pkg::CRS_ST_IDLE && !mem_req_o;
  endproperty
  a_en_idle: assert property (p_en_idle)
    else $error("disabled scanner is fetching");

  property p_go_clear;
    (q.scan_st == crs_pkg::CRS_ST_IDLE) & q.scan_go_a & past_end &
      ~(wr & (paddr_i == `CRS_OFF_SCAN_CTRL)) |=> !q.scan_go_a;
  endproperty
  a_go_clear: assert property (p_go_clear)
    else $error("go not cleared past end address");

  property p_irq_block;
    q.interrupt_management & irq_active_i &
      (q.mode != crs_pkg::CRS_MODE_PEEK) &
      (q.scan_st == crs_pkg::CRS_ST_IDLE) |=> !mem_req_o;
  endproperty
  a_irq_block: assert property (p_irq_block)
    else $error("fetch started during masked interrupt");

  property p_busy;
    mem_req_o |-> sc_rd[`CRS_SC_BUSY];
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy low during memory fetch");

  property p_addr_inc;
    done |=> q.scan_current_address ==
             $past(q.scan_current_address) + 16'h0001 ##0 q.full;
  endproperty
  a_addr_inc: assert property (p_addr_inc)
    else $error("current address did not step after fetch");

  property p_addr_lock;
    q.scan_go_a & ~done |=>
      q.scan_current_address == $past(q.scan_current_address) &&
      q.scan_end_address == $past(q.scan_end_address);
  endproperty
  a_addr_lock: assert property (p_addr_lock)
    else $error("address changed by write while go set");

  property p_bit_count;
    step & (q.bit_cnt == 5'h01) |=> q.bit_cnt == 5'h00 ##1 1'b1;
  endproperty
  a_bit_count: assert property (p_bit_count)
    else $error("bit counter did not end at zero");

  property p_bit_step;
    step |=> q.bit_cnt == $past(q.bit_cnt) - 5'h01;
  endproperty
  a_bit_step: assert property (p_bit_step)
    else $error("bit counter did not step with the shift");

  property p_invalid_wrap;
    done & ~wr & ({1'b0, q.scan_current_address} == MEM_WORDS - 17'h00001)
      |=> sc_rd[`CRS_SC_INVALID];
  endproperty
  a_invalid_wrap: assert property (p_invalid_wrap)
    else $error("invalid flag clear after last program word");

  property p_no_go_no_fetch;
    (q.scan_st == crs_pkg::CRS_ST_IDLE) & !q.scan_go_a |=> !mem_req_o;
  endproperty
  a_no_go_no_fetch: assert property (p_no_go_no_fetch)
    else $error("fetch started with go clear");

  property p_burst_stall;
    (q.mode == crs_pkg::CRS_MODE_BURST) & q.scan_en & q.scan_go_a &
      !q.interrupt_management & !past_end |-> cpu_stall_o;
  endproperty
  a_burst_stall: assert property (p_burst_stall)
    else $error("burst scan did not stall the CPU");

  c_burst: cover property (start & (q.mode == crs_pkg::CRS_MODE_BURST)
                           ##[1:20] done);
  c_trig: cover property (trigger_i ##[1:20] start &
                          (q.mode == crs_pkg::CRS_MODE_TRIGGERED));
  c_end: cover property (q.scan_go_a ##[1:200] !q.scan_go_a);
  c_peek: cover property (start & (q.mode == crs_pkg::CRS_MODE_PEEK));
endmodule : crs_top

// ===== tb/crs_flash_model.sv
// Program flash model that answers scanner fetches
`timescale 1ns/1ps
module crs_flash_model #(
  parameter logic [15:0] KEY = 16'h5a3c
) (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        mem_req_i,
  input  wire logic [15:0] mem_addr_i,
  input  wire logic [3:0]  lat_i,
  output logic             mem_ack_o,
  output logic      [15:0] mem_data_o,
  output logic      [15:0] fetch_cnt_o
);
  logic [3:0] wait_q;
  // Word is valid in the ack cycle and the cycle after; otherwise the data bus toggles
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mem_ack_o   <= 1'b0;
      mem_data_o  <= 16'h0000;
      fetch_cnt_o <= 16'h0000;
      wait_q      <= 4'h0;
    end else begin
      mem_ack_o <= 1'b0;
      if (mem_req_i && !mem_ack_o && wait_q == lat_i) begin
        mem_ack_o   <= 1'b1;
        mem_data_o  <= mem_addr_i ^ KEY;
        fetch_cnt_o <= fetch_cnt_o + 16'h0001;
        wait_q      <= 4'h0;
      end else if (!mem_ack_o) begin
        mem_data_o <= ~mem_data_o;
        if (mem_req_i) begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule : crs_flash_model

// ===== tb/tb.sv
// Testbench: registers, CRC engine and memory scanner over APB
`timescale 1ns/1ps
`include "crs_map.svh"
module tb;
  localparam logic [15:0] KEY = 16'h5a3c;
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        trigger = 1'b0;
  logic        idle = 1'b1;
  logic        irq = 1'b0;
  logic [3:0]  lat = 4'h0;
  logic        stall_seen = 1'b0;
  logic [31:0] prdata_o, rd;
  logic        pready_o, pslverr_o, err, mem_req, mem_ack;
  logic        cpu_stall_o, crc_busy_o;
  logic [15:0] mem_addr, mem_data, fetch_cnt, base, exp;
  logic [7:0]  c;
  int          miscompares = 0;
  int          n_compared = 0;

  crs_top #(.MEM_WORDS(17'h04000)) dut_u (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .mem_req_o(mem_req), .mem_addr_o(mem_addr),
    .mem_ack_i(mem_ack), .mem_data_i(mem_data), .mem_idle_i(idle),
    .trigger_i(trigger), .irq_active_i(irq), .cpu_stall_o(cpu_stall_o),
    .crc_busy_o(crc_busy_o));

  crs_flash_model #(.KEY(KEY)) flash_u (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .mem_req_i(mem_req),
    .mem_addr_i(mem_addr), .lat_i(lat), .mem_ack_o(mem_ack),
    .mem_data_o(mem_data), .fetch_cnt_o(fetch_cnt));

  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) if (cpu_stall_o === 1'b1) stall_seen <= 1'b1;

  // ****************************************************************
  // Bus tasks and checks
  // ****************************************************************
  task report_and_stop;
    $display("compared %0d, wrong %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  task ran_out;
    miscompares++;
    $display("wrong value at %0t: wait ran out", $time);
    report_and_stop();
  endtask : ran_out

  task chk(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      miscompares++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : chk

  task apb(input logic [11:0] a, input logic w, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1) ran_out();
    rd = prdata_o;
    err = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(a, 1'b1, d);
  endtask : wr

  task rd_chk(input logic [11:0] a, input logic [7:0] e);
    apb(a, 1'b0, 8'h00);
    chk(rd, {24'h0, e});
  endtask : rd_chk

  task set_range(input logic [15:0] s, input logic [15:0] e);
    wr(`CRS_OFF_CUR_HIGH, s[15:8]);
    wr(`CRS_OFF_CUR_LOW, s[7:0]);
    wr(`CRS_OFF_END_HIGH, e[15:8]);
    wr(`CRS_OFF_END_LOW, e[7:0]);
    base = fetch_cnt;
  endtask : set_range

  task wait_crc;
    int i;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (crc_busy_o !== 1'b0 && i < 100);
    if (crc_busy_o !== 1'b0) ran_out();
  endtask : wait_crc

  task wait_scan;
    int i;
    for (i = 0; i < 100; i++) begin
      apb(`CRS_OFF_SCAN_CTRL, 1'b0, 8'h00);
      if (rd[6] === 1'b0) break;
    end
    if (rd[6] !== 1'b0) ran_out();
    wait_crc();
  endtask : wait_scan

  function automatic logic [15:0] crc(logic [15:0] acc, logic [15:0] d,
                                      int nb, logic lsb, logic aug);
    logic b, fb;
    int i;
    for (i = 0; i < nb; i++) begin
      b = lsb ? d[i] : d[nb-1-i];
      fb = aug ? acc[15] : acc[15] ^ b;
      acc = {acc[14:0], aug & b};
      if (fb) acc = acc ^ 16'h1021;
    end
    return acc;
  endfunction : crc

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd_chk(`CRS_OFF_ACC_HIGH, 8'h00);
    rd_chk(`CRS_OFF_SHIFT_LOW, 8'h00);
    rd_chk(`CRS_OFF_TAPS_LOW, 8'h01);
    rd_chk(`CRS_OFF_SCAN_CTRL, 8'h00);
    rd_chk(`CRS_OFF_CUR_HIGH, 8'h00);
    rd_chk(`CRS_OFF_END_HIGH, 8'h00);
    wr(`CRS_OFF_ACC_HIGH, 8'ha5);
    wr(`CRS_OFF_ACC_LOW, 8'h3c);
    wr(`CRS_OFF_SHIFT_HIGH, 8'hff);
    wr(`CRS_OFF_TAPS_LOW, 8'hfe);
    rd_chk(`CRS_OFF_ACC_HIGH, 8'ha5);
    rd_chk(`CRS_OFF_ACC_LOW, 8'h3c);
    rd_chk(`CRS_OFF_SHIFT_HIGH, 8'h00);
    rd_chk(`CRS_OFF_TAPS_LOW, 8'hff);
    wr(`CRS_OFF_TAPS_LOW, 8'h20);
    wr(`CRS_OFF_TAPS_HIGH, 8'h10);
    rd_chk(`CRS_OFF_TAPS_LOW, 8'h21);
    apb(12'h0fc, 1'b0, 8'h00);
    chk({err, rd[30:0]}, 32'h80000000);
    wr(`CRS_OFF_CRC_LEN, 8'h7f);
    for (int m = 0; m < 4; m++) begin
      c = 8'hc0 | (m[1] ? 8'h10 : 8'h00) | (m[0] ? 8'h02 : 8'h00);
      wr(`CRS_OFF_ACC_HIGH, 8'h00);
      wr(`CRS_OFF_ACC_LOW, 8'h00);
      wr(`CRS_OFF_CRC_CTRL, c);
      wr(`CRS_OFF_DATA_HIGH, 8'h00);
      wr(`CRS_OFF_DATA_LOW, 8'h31);
      wait_crc();
      exp = crc(16'h0000, 16'h0031, 8, m[0], m[1]);
      rd_chk(`CRS_OFF_ACC_HIGH, exp[15:8]);
      rd_chk(`CRS_OFF_ACC_LOW, exp[7:0]);
      rd_chk(`CRS_OFF_CRC_CTRL, c);
    end
    wr(`CRS_OFF_CRC_LEN, 8'hff);
    wr(`CRS_OFF_CRC_CTRL, 8'hc0);
    wr(`CRS_OFF_ACC_HIGH, 8'h00);
    wr(`CRS_OFF_ACC_LOW, 8'h00);
    lat <= 4'h6;
    irq <= 1'b1;
    set_range(16'h3ffe, 16'h3fff);
    wr(`CRS_OFF_SCAN_CTRL, 8'hc0);
    wr(`CRS_OFF_CUR_LOW, 8'h00);
    wait_scan();
    chk({16'h0, fetch_cnt - base}, 32'h2);
    rd_chk(`CRS_OFF_CUR_HIGH, 8'h40);
    rd_chk(`CRS_OFF_CUR_LOW, 8'h00);
    apb(`CRS_OFF_SCAN_CTRL, 1'b0, 8'h00);
    chk(rd & 32'hd0, 32'h90);
    exp = crc(crc(16'h0, 16'h3ffe ^ KEY, 16, 1'b0, 1'b0),
              16'h3fff ^ KEY, 16, 1'b0, 1'b0);
    rd_chk(`CRS_OFF_ACC_HIGH, exp[15:8]);
    wr(`CRS_OFF_SCAN_CTRL, 8'h00);
    rd_chk(`CRS_OFF_ACC_LOW, exp[7:0]);
    rd_chk(`CRS_OFF_CUR_HIGH, 8'h40);
    lat <= 4'h3;
    set_range(16'h0010, 16'h0011);
    wr(`CRS_OFF_SCAN_CTRL, 8'hc9);
    repeat (20) @(posedge clk_i);
    chk({16'h0, fetch_cnt - base}, 32'h0);
    apb(`CRS_OFF_SCAN_CTRL, 1'b0, 8'h00);
    chk({rd[6], stall_seen}, 32'h2);
    irq <= 1'b0;
    wait_scan();
    chk({stall_seen, fetch_cnt - base}, 32'h10002);
    set_range(16'h0020, 16'h0020);
    wr(`CRS_OFF_SCAN_CTRL, 8'hc3);
    repeat (20) @(posedge clk_i);
    chk({16'h0, fetch_cnt - base}, 32'h0);
    trigger <= 1'b1;
    @(posedge clk_i);
    trigger <= 1'b0;
    wait_scan();
    chk({16'h0, fetch_cnt - base}, 32'h1);
    chk(rd & 32'hd0, 32'h80);
    irq <= 1'b1;
    set_range(16'h0030, 16'h0030);
    wr(`CRS_OFF_SCAN_CTRL, 8'h4a);
    repeat (20) @(posedge clk_i);
    chk({16'h0, fetch_cnt - base}, 32'h0);
    idle <= 1'b0;
    wr(`CRS_OFF_SCAN_CTRL, 8'hca);
    repeat (20) @(posedge clk_i);
    apb(`CRS_OFF_SCAN_CTRL, 1'b0, 8'h00);
    chk({fetch_cnt - base, rd[7:0] & 8'h60}, 32'h60);
    idle <= 1'b1;
    wait_scan();
    chk({16'h0, fetch_cnt - base}, 32'h1);
    report_and_stop();
  end
endmodule : tb
